/* File: refresh_controller_interval_timer.sv */
// Refresh controller for memory area 3: refresh timer, bus request and standby pin states.
// Assumes a wait state unit and pin pads sit outside; the bus grant priority is decided here.
`include "refresh_params.svh"
module refresh_controller_interval_timer #(
    parameter int PRESCALE_W = 14
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_srst,
    input  wire logic [2:0]            i_addr,
    input  wire logic [7:0]            i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic      [7:0]            o_rdata,
    input  wire logic                  i_sleep,
    input  wire logic                  i_sw_standby,
    input  wire logic                  i_hw_standby,
    input  wire logic                  i_ext_master_req,
    input  wire logic                  i_dma_req,
    input  wire logic                  i_cpu_req,
    input  wire logic                  i_wait_req,
    output logic                       o_grant_ext,
    output logic                       o_grant_refresh,
    output logic                       o_grant_dma,
    output logic                       o_grant_cpu,
    output logic                       o_refresh_busy,
    output logic                       o_wait_allowed,
    output logic                       o_compare_interrupt,
    output logic                       o_upper_write_strobe,
    output logic                       o_upper_write_strobe_oe_n,
    output logic                       o_lower_write_strobe,
    output logic                       o_lower_write_strobe_oe_n,
    output logic                       o_read_strobe,
    output logic                       o_read_strobe_oe_n,
    output logic                       o_area3_select,
    output logic                       o_refresh_strobe,
    output refresh_pkg::mem_mode_t     o_mode
);
    import refresh_pkg::*;

    initial begin
        // The top clock select picks prescaler bit 13, so fewer bits cannot serve it.
        if (PRESCALE_W < 14 || PRESCALE_W > 16) begin
            $error("PRESCALE_W must lie between 14 and 16");
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [7:0]            refresh_timer_count;
    logic [7:0]            refresh_time_constant;
    logic                  compare_match_flag;
    logic                  compare_interrupt_enable;
    logic [2:0]            clock_select_field;
    logic [7:0]            refresh_control_reg;
    logic                  area3_three_state;
    logic [PRESCALE_W-1:0] prescaler;
    logic                  tap_prev;
    logic                  flag_seen;
    logic                  standby_prev;
    logic [1:0]            state_count;
    refresh_state_t        state;
    refresh_state_t        next_state;

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    // Pin inputs cross into the clock domain through two stages each.
    localparam int N_PINS = 5;
    logic [N_PINS-1:0] pin_raw;
    logic [N_PINS-1:0] pin_meta;
    logic [N_PINS-1:0] pin_sync;
    assign pin_raw = {i_sleep, i_sw_standby, i_hw_standby, i_ext_master_req, i_wait_req};

    genvar g;
    generate
        for (g = 0; g < N_PINS; g++) begin : g_pin_sync
            always_ff @(posedge i_clk) begin
                pin_meta[g] <= pin_raw[g];
                pin_sync[g] <= pin_meta[g];
            end
        end
    endgenerate
    wire sleep_s      = pin_sync[4];
    wire sw_standby   = pin_sync[3];
    wire hw_standby   = pin_sync[2];
    wire ext_req      = pin_sync[1];
    wire wait_req     = pin_sync[0];

    // ------------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------------
    wire self_refresh_select = refresh_control_reg[`RFC_SELF_REFRESH_BIT];
    wire pseudo_sram_enable  = refresh_control_reg[`RFC_PSRAM_EN_BIT];
    wire dynamic_ram_enable  = refresh_control_reg[`RFC_DRAM_EN_BIT];
    wire dual_column_mode    = refresh_control_reg[`RFC_DUAL_COLUMN_BIT];
    wire dual_write_mode     = ~dual_column_mode;
    wire cycle_enable        = refresh_control_reg[`RFC_CYCLE_EN_BIT];
    wire mem_enabled         = pseudo_sram_enable | dynamic_ram_enable;
    wire config_locked       = mem_enabled;
    wire run                 = ~hw_standby & ~sw_standby;
    wire standby_entry       = sw_standby & ~standby_prev;

    function automatic logic hit(input logic [2:0] a);
        hit = (i_addr == a);
    endfunction

    wire wr_csr   = i_wr & hit(`OFS_CONTROL_STATUS) & ~config_locked;
    wire wr_cnt   = i_wr & hit(`OFS_COUNT);
    wire wr_cor   = i_wr & hit(`OFS_TIME_CONSTANT) & ~config_locked;
    wire wr_rfc   = i_wr & hit(`OFS_REFRESH_CONTROL) & ~config_locked;
    wire wr_ast   = i_wr & hit(`OFS_ACCESS_STATE);

    // Prescaler taps; select 0 halts, select n picks bit 2n-1.
    function automatic logic tap_of(input logic [2:0] sel, input logic [PRESCALE_W-1:0] p);
        logic [3:0] idx;
        idx    = {sel, 1'b0} - 4'h1;
        tap_of = (sel == `CKS_HALTED) ? 1'b0 : p[idx];
    endfunction

    // A switch from a high to a low or halted source looks like a falling edge.
    wire tap_now    = tap_of(clock_select_field, prescaler);
    wire count_tick = run & tap_prev & ~tap_now;
    wire at_match   = (refresh_timer_count == refresh_time_constant);
    wire match_raw  = count_tick & at_match;
    wire compare_match = match_raw & ~wr_cor;
    wire first_flag    = compare_match & ~flag_seen;

    // ------------------------------------------------------------------------
    // Counter, prescaler and status
    // ------------------------------------------------------------------------
    // The prescaler is held at zero during standby so that a restart begins a full period.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            prescaler <= '0;
        end else if (run) begin
            prescaler <= prescaler + 1'b1;
        end else begin
            prescaler <= '0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            tap_prev <= 1'b0;
        end else begin
            tap_prev <= tap_now;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            standby_prev <= 1'b0;
        end else begin
            standby_prev <= sw_standby;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst || standby_entry) begin
            refresh_timer_count <= `RST_COUNT;
        end else if (compare_match) begin
            refresh_timer_count <= `RST_COUNT;
        end else if (wr_cnt) begin
            refresh_timer_count <= i_wdata;
        end else if (count_tick) begin
            refresh_timer_count <= refresh_timer_count + 8'h01;
        end
    end

    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            refresh_time_constant <= `RST_TIME_CONSTANT;
        end else if (wr_cor) begin
            refresh_time_constant <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            clock_select_field <= `CKS_HALTED;
        end else if (wr_csr) begin
            clock_select_field <= i_wdata[`CSR_CKS_HI:`CSR_CKS_LO];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            area3_three_state <= 1'b0;
        end else if (wr_ast) begin
            area3_three_state <= i_wdata[0];
        end
    end

    // Enable bits stay writable so software can release the lock.
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            refresh_control_reg <= `RST_REFRESH_CONTROL;
        end else if (wr_rfc) begin
            refresh_control_reg <= i_wdata;
        end else if (i_wr && hit(`OFS_REFRESH_CONTROL)) begin
            refresh_control_reg[`RFC_PSRAM_EN_BIT] <= i_wdata[`RFC_PSRAM_EN_BIT];
            refresh_control_reg[`RFC_DRAM_EN_BIT]  <= i_wdata[`RFC_DRAM_EN_BIT];
        end
    end

    // ------------------------------------------------------------------------
    // Compare match flag and interrupt enable
    // ------------------------------------------------------------------------
    // The flag sets over a clear in the same cycle; software clears by writing zero.
    always_ff @(posedge i_clk) begin
        if (i_srst || standby_entry) begin
            compare_match_flag <= 1'b0;
        end else if (compare_match) begin
            compare_match_flag <= 1'b1;
        end else if (wr_csr && !i_wdata[`CSR_FLAG_BIT]) begin
            compare_match_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst || standby_entry) begin
            compare_interrupt_enable <= 1'b0;
        end else if (wr_csr) begin
            compare_interrupt_enable <= i_wdata[`CSR_IRQ_EN_BIT];
        end
    end

    // ------------------------------------------------------------------------
    // Refresh sequencing and arbitration
    // ------------------------------------------------------------------------
    wire refresh_mode = mem_enabled & cycle_enable;
    wire bus_grant_refresh = ~ext_req;
    wire cycle_done = (state_count == `REFRESH_STATES - 2'h1) & ~(area3_three_state & wait_req);

    always_comb begin
        next_state = state;
        case (state)
            st_idle:     next_state = (refresh_mode && compare_match) ? st_pending : st_idle;
            st_pending:  next_state = compare_match ? st_wait_bus : st_pending;
            st_wait_bus: next_state = bus_grant_refresh ? st_cycle : st_wait_bus;
            st_cycle:    next_state = cycle_done ? st_pending : st_cycle;
            default:     next_state = st_idle;
        endcase
        if (!refresh_mode) next_state = st_idle;
    end

    // Any standby drops a pending request, so the first match afterwards only pends again.
    always_ff @(posedge i_clk) begin
        if (i_srst || standby_entry || !run) begin
            state <= st_idle;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst || standby_entry || !run) begin
            flag_seen <= 1'b0;
        end else if (first_flag) begin
            flag_seen <= 1'b1;
        end
    end

    // A stalled refresh holds its state count, which is how wait states stretch the cycle.
    always_ff @(posedge i_clk) begin
        if (i_srst || standby_entry || !run || state != st_cycle) begin
            state_count <= 2'h0;
        end else if (!(area3_three_state && wait_req)) begin
            state_count <= state_count + 2'h1;
        end
    end

    wire refresh_req = (state == st_wait_bus) | (state == st_cycle);
    assign o_grant_ext     = ext_req;
    assign o_grant_refresh = ~ext_req & refresh_req;
    assign o_grant_dma     = ~ext_req & ~refresh_req & i_dma_req;
    assign o_grant_cpu     = ~ext_req & ~refresh_req & ~i_dma_req & i_cpu_req;
    assign o_refresh_busy  = (state == st_cycle);
    assign o_wait_allowed  = area3_three_state;
    assign o_compare_interrupt = ~mem_enabled & compare_match_flag & compare_interrupt_enable;
    assign o_mode = dynamic_ram_enable ? mode_dram : (pseudo_sram_enable ? mode_psram : mode_interval);

    // ------------------------------------------------------------------------
    // Standby pin states
    // ------------------------------------------------------------------------
    wire dram_sb  = sw_standby & dynamic_ram_enable;
    wire psram_sb = sw_standby & pseudo_sram_enable & ~dynamic_ram_enable;
    wire self_ref = self_refresh_select;
    wire dram_drv = dram_sb & self_ref;
    wire pins_parked = dram_sb | psram_sb;

    // Outside standby the strobes idle high and driven; the bus cycle logic owns them then.
    wire next_write_strobe   = dram_drv ? dual_write_mode : 1'b1;
    wire next_read_strobe    = dram_drv ? dual_column_mode : 1'b1;
    wire next_strobe_oe_n    = pins_parked ? ~dram_drv : 1'b0;
    wire next_area3_select   = ~dram_drv & ~o_refresh_busy;
    wire next_refresh_strobe = ~(pins_parked & self_ref) & ~o_refresh_busy;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_upper_write_strobe      <= 1'b1;
            o_upper_write_strobe_oe_n <= 1'b1;
            o_lower_write_strobe      <= 1'b1;
            o_lower_write_strobe_oe_n <= 1'b1;
            o_read_strobe             <= 1'b1;
            o_read_strobe_oe_n        <= 1'b1;
            o_area3_select            <= 1'b1;
            o_refresh_strobe          <= 1'b1;
        end else begin
            o_upper_write_strobe      <= next_write_strobe;
            o_lower_write_strobe      <= next_write_strobe;
            o_read_strobe             <= next_read_strobe;
            o_upper_write_strobe_oe_n <= next_strobe_oe_n;
            o_lower_write_strobe_oe_n <= next_strobe_oe_n;
            o_read_strobe_oe_n        <= next_strobe_oe_n;
            o_area3_select            <= next_area3_select;
            o_refresh_strobe          <= next_refresh_strobe;
        end
    end

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    // Read data are zero outside the answer cycle, so several slaves may share one return path.
    wire [7:0] csr_value = {compare_match_flag, compare_interrupt_enable, clock_select_field, 3'h0};
    wire [7:0] rd_mux =
        hit(`OFS_CONTROL_STATUS)  ? csr_value :
        hit(`OFS_COUNT)           ? refresh_timer_count :
        hit(`OFS_TIME_CONSTANT)   ? refresh_time_constant :
        hit(`OFS_REFRESH_CONTROL) ? refresh_control_reg :
        hit(`OFS_ACCESS_STATE)    ? {7'h00, area3_three_state} :
        hit(`OFS_POWER_STATE)     ? {5'h00, sleep_s, sw_standby, hw_standby} : 8'h00;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= i_rd ? rd_mux : 8'h00;
        end
    end
endmodule : refresh_controller_interval_timer

/* File: refresh_params.svh */
// Holds register offsets, field positions, reset values and encodings for the refresh controller.
// Assumes inclusion by bare name from the package and the design module.
`ifndef REFRESH_PARAMS_SVH
`define REFRESH_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_CONTROL_STATUS   3'h0
`define OFS_COUNT            3'h1
`define OFS_TIME_CONSTANT    3'h2
`define OFS_REFRESH_CONTROL  3'h3
`define OFS_ACCESS_STATE     3'h4
`define OFS_POWER_STATE      3'h5

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CSR_FLAG_BIT         7
`define CSR_IRQ_EN_BIT       6
`define CSR_CKS_HI           5
`define CSR_CKS_LO           3
`define RFC_SELF_REFRESH_BIT 7
`define RFC_PSRAM_EN_BIT     6
`define RFC_DRAM_EN_BIT      5
`define RFC_DUAL_COLUMN_BIT  4
`define RFC_CYCLE_EN_BIT     2

// ----------------------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------------------
`define RST_COUNT            8'h00
`define RST_TIME_CONSTANT    8'hFF
`define RST_CONTROL_STATUS   8'h00
`define RST_REFRESH_CONTROL  8'h00
`define CKS_HALTED           3'h0
`define REFRESH_STATES       2'h3

`endif

/* File: refresh_pkg.sv */
// Holds the types shared by the refresh controller and its bench.
// Assumes the parameter header is on the include path.
`include "refresh_params.svh"
package refresh_pkg;
    typedef enum logic [1:0] {
        mode_interval,
        mode_dram,
        mode_psram
    } mem_mode_t;

    typedef enum {
        st_idle,
        st_pending,
        st_wait_bus,
        st_cycle
    } refresh_state_t;
endpackage : refresh_pkg

/* File: refresh_monitor.sv */
// Concurrent checks on the ports of the refresh controller.
// Assumes one clock domain with a synchronous active-high reset.
module refresh_monitor
    import refresh_pkg::*;
(
    input wire logic      i_clk,
    input wire logic      i_srst,
    input wire logic [2:0] i_addr,
    input wire logic      i_wr,
    input wire logic      i_rd,
    input wire logic      i_dma_req,
    input wire logic [7:0] o_rdata,
    input wire logic      o_grant_ext,
    input wire logic      o_grant_refresh,
    input wire logic      o_grant_dma,
    input wire logic      o_grant_cpu,
    input wire logic      o_refresh_busy,
    input wire logic      o_wait_allowed,
    input wire logic      o_compare_interrupt,
    input wire logic      o_upper_write_strobe_oe_n,
    input wire logic      o_lower_write_strobe_oe_n,
    input wire logic      o_read_strobe_oe_n,
    input wire logic      o_area3_select,
    input wire logic      o_refresh_strobe,
    input wire mem_mode_t o_mode
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside the read answer cycle");
    a_grant_one_hot: assert property ($onehot0({o_grant_ext, o_grant_refresh,
        o_grant_dma, o_grant_cpu}))
        else $error("more than one bus grant at once");
    a_dma_over_cpu: assert property (i_dma_req && !o_grant_ext && !o_grant_refresh
        |-> o_grant_dma)
        else $error("dma request not granted over the cpu");
    a_refresh_three_states: assert property ($rose(o_refresh_busy) && !o_wait_allowed
        |-> o_refresh_busy [*3] ##1 !o_refresh_busy)
        else $error("refresh cycle not three states long");
    a_irq_interval_only: assert property (o_compare_interrupt |-> o_mode == mode_interval)
        else $error("compare interrupt while a memory enable is set");
    a_strobes_float_together: assert property (o_read_strobe_oe_n
        |-> o_upper_write_strobe_oe_n && o_lower_write_strobe_oe_n)
        else $error("read strobe floats without the write strobes");
    a_psram_select_high: assert property (o_mode == mode_psram && o_read_strobe_oe_n
        |-> o_area3_select)
        else $error("area select low while psram strobes float");
    a_dram_float_high: assert property (o_mode == mode_dram && o_read_strobe_oe_n
        |-> o_area3_select && o_refresh_strobe)
        else $error("dram select or refresh low while strobes float");
    a_mode_by_write: assert property (o_mode != $past(o_mode)
        |-> $past(i_wr) && $past(i_addr) == 3'h3)
        else $error("mode changed without a refresh control write");
endmodule : refresh_monitor

bind refresh_controller_interval_timer refresh_monitor i_refresh_monitor (.*);

/* File: memory_model.sv */
// Far-side memory model: stalls refresh cycles when told to be slow.
// Assumes it watches the block's refresh busy level on the same clock.
module memory_model (
    input  wire logic i_clk,
    input  wire logic i_slow,
    input  wire logic i_busy,
    output logic      o_wait_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] busy_cycles;
    // A slow part holds its wait request from before a refresh until the refresh has run two
    // cycles, since the request reaches the block only after its input synchronisers.
    always_ff @(posedge i_clk) begin
        if (!i_busy) begin
            busy_cycles <= 3'h0;
        end else if (busy_cycles != 3'h7) begin
            busy_cycles <= busy_cycles + 3'h1;
        end
    end
    always_ff @(posedge i_clk) begin
        o_wait_req <= i_slow && !(i_busy && busy_cycles >= 3'h2);
    end
endmodule : memory_model

/* File: refresh_controller_interval_timer_tb.sv */
// Self-checking bench for the refresh controller and interval timer.
// Assumes the memory model and the bound monitor are compiled alongside.
`define CHECK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %s expected %h seen %h", nm, e, g); end end
module refresh_controller_interval_timer_tb;
    import refresh_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0, i_srst = 1, i_wr = 0, i_rd = 0, i_sw_standby = 0;
    logic i_ext_master_req = 0, i_dma_req = 0, i_cpu_req = 0, slow = 0, i_wait_req;
    logic [2:0] i_addr = 3'h0;
    logic [7:0] i_wdata = 8'h00, o_rdata, d;
    logic gx, gr, gd, gc, busy, wait_ok, irq, us, uo, ls, lo, rs, ro, sel, rf;
    mem_mode_t mode;
    int n_mismatch = 0, comparisons = 0, cycles = 0, n;

    refresh_controller_interval_timer i_refresh_controller_interval_timer (
        .i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sleep(1'b0),
        .i_sw_standby(i_sw_standby), .i_hw_standby(1'b0),
        .i_ext_master_req(i_ext_master_req), .i_dma_req(i_dma_req),
        .i_cpu_req(i_cpu_req), .i_wait_req(i_wait_req), .o_grant_ext(gx),
        .o_grant_refresh(gr), .o_grant_dma(gd), .o_grant_cpu(gc),
        .o_refresh_busy(busy), .o_wait_allowed(wait_ok), .o_compare_interrupt(irq),
        .o_upper_write_strobe(us), .o_upper_write_strobe_oe_n(uo),
        .o_lower_write_strobe(ls), .o_lower_write_strobe_oe_n(lo),
        .o_read_strobe(rs), .o_read_strobe_oe_n(ro), .o_area3_select(sel),
        .o_refresh_strobe(rf), .o_mode(mode));
    memory_model i_memory_model (.i_clk(i_clk), .i_slow(slow), .i_busy(busy),
        .o_wait_req(i_wait_req));

    initial begin
        forever #4 i_clk = ~i_clk;
    end
    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task cyc(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask : cyc
    task wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge i_clk);
        i_addr <= a; i_wdata <= v; i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task rd(input logic [2:0] a);
        @(posedge i_clk);
        i_addr <= a; i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd
    task standby(input logic v);
        @(posedge i_clk);
        i_sw_standby <= v;
        cyc(5);
    endtask : standby
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_reset;
        rd(3'h2); `CHECK("time constant", 8'hFF, d)
        rd(3'h0); `CHECK("control status", 8'h00, d)
        rd(3'h1); `CHECK("count", 8'h00, d)
        rd(3'h6); `CHECK("unmapped", 8'h00, d)
    endtask : t_reset
    task t_interval;
        wr(3'h2, 8'h02); wr(3'h0, 8'h48);
        n = 0;
        do begin rd(3'h0); n++; end while (d[7] !== 1'b1 && n < 200);
        `CHECK("match flag", 1'b1, d[7])
        `CHECK("interrupt on", 1'b1, irq)
        wr(3'h0, 8'h08); cyc(2);
        `CHECK("interrupt masked", 1'b0, irq)
    endtask : t_interval
    task t_standby;
        wr(3'h0, 8'h68); wr(3'h1, 8'h10); standby(1); standby(0);
        rd(3'h1); `CHECK("count after standby", 8'h00, d)
        rd(3'h0); `CHECK("status after standby", 8'h28, d)
        rd(3'h2); `CHECK("constant after standby", 8'h02, d)
    endtask : t_standby
    task t_priority;
        for (int k = 0; k < 8; k++) begin
            @(posedge i_clk);
            {i_ext_master_req, i_dma_req, i_cpu_req} <= k[2:0];
            cyc(4);
            `CHECK("grants", k[2] ? 4'h8 : k[1] ? 4'h2 : k[0] ? 4'h1 : 4'h0,
                {gx, gr, gd, gc})
        end
        @(posedge i_clk);
        {i_ext_master_req, i_dma_req, i_cpu_req} <= 3'h0;
    endtask : t_priority
    task t_pins;
        logic [7:0] cfg [5] = '{8'h20, 8'hA0, 8'hB0, 8'h40, 8'hC0};
        logic [7:0] exp [5] = '{8'hF8, 8'h06, 8'h01, 8'hF8, 8'hF0};
        for (int k = 0; k < 5; k++) begin
            wr(3'h3, 8'h00); wr(3'h3, cfg[k]); standby(1);
            `CHECK("standby pins", exp[k], {uo, lo, ro, sel, rf, us & ~uo, ls & ~lo,
                rs & ~ro})
            standby(0);
            `CHECK("refresh pin after standby", 1'b1, rf)
            rd(3'h2); `CHECK("constant kept", 8'h02, d)
            wr(3'h2, 8'h33); rd(3'h2); `CHECK("locked constant", 8'h02, d)
        end
    endtask : t_pins
    task t_refresh;
        wr(3'h3, 8'h00); wr(3'h2, 8'h01); wr(3'h0, 8'h08); wr(3'h4, 8'h00);
        wr(3'h3, 8'h24);
        n = 0;
        while (busy !== 1'b1 && n < 300) begin cyc(1); n++; end
        `CHECK("first request only pends", 1'b1, n > 8)
        n = 0;
        while (busy === 1'b1 && n < 50) begin cyc(1); n++; end
        `CHECK("refresh length", 3, n)
        wr(3'h4, 8'h01); @(posedge i_clk); slow <= 1'b1; cyc(1);
        `CHECK("wait allowed", 1'b1, wait_ok)
        n = 0;
        while (busy !== 1'b1 && n < 300) begin cyc(1); n++; end
        n = 0;
        while (busy === 1'b1 && n < 50) begin cyc(1); n++; end
        `CHECK("stretched refresh", 1'b1, n > 3)
    endtask : t_refresh
    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    // The ceiling is well above the few hundred cycles the scenarios need.
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        repeat (4) @(posedge i_clk);
        i_srst <= 1'b0;
        t_reset(); t_interval(); t_standby(); t_priority(); t_pins(); t_refresh();
        report_and_stop();
    end
endmodule : refresh_controller_interval_timer_tb
